// [shared/card_detect_cfg.svh]
// Constants of the card presence detect register block.
// Assumes inclusion by bare name into design files.
`ifndef CARD_DETECT_CFG_SVH
`define CARD_DETECT_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_OPTIONS 8'h3a
`define IDX_Q_LOW 8'h3f
`define IDX_Q_HIGH 8'h40
`define IDX_I_LOW 8'h41
`define IDX_I_RES 8'h42
`define IDX_Q_RES 8'h43
`define IDX_IRQ_STAT 8'h50
`define IDX_IRQ_MASK 8'h51
// Field positions
`define THR_LSB 0
`define THR_MSB 5
`define IUP_LSB 6
`define IUP_MSB 7
`define SUPPRESS_BIT 6
`define TX_FULL_BIT 3
`define FILTER_BIT 2
`define Q_UNSTABLE_BIT 1
`define I_UNSTABLE_BIT 0
`define EVT_DETECT_BIT 0
`define EVT_UNSTABLE_BIT 1
// Reset values
`define REG8_RESET 8'h00
`define EVT_RESET 2'h0
`define DATA_RESET 32'h0000_0000
// Sampling window
`define CLK_PERIOD_NS 10
`define SAMPLE_TIME_NS 4720
`define SAMPLE_CYCLES (`SAMPLE_TIME_NS / `CLK_PERIOD_NS)
`endif

// [shared/card_detect_pkg.sv]
// Types of the card presence detect register block.
// Assumes the constants header is compiled alongside.
package card_detect_pkg;
  typedef logic [5:0] meas_t;
  typedef logic [7:0] reg8_t;
  typedef logic [1:0] evt_t;
  typedef enum logic [0:0] {
    MEAS_IDLE = 1'b0,
    MEAS_RUN = 1'b1
  } meas_state_t;
endpackage

// [design/card_detect_threshold_regs.sv]
// Threshold registers, compare logic and event interrupt for
// low power card presence detection.
// Assumes an APB master on clk_sys and a front end giving
// start, sample and done pulses synchronous to clk_sys.
// Notes on behaviour
// - upper I threshold gathered from three top bit pairs
// - I above upper threshold flags detection
// - Q above lower threshold flags detection
// - Q above upper threshold flags detection
// - I below lower threshold flags detection
// - thresholds at 3Fh-41h, results at 42h-43h
// - I result read only, top bits reserved
// - Q result read only, bit 7 reserved
// - suppress bit blocks detection until next start
// - options register only on newer variant
// - full swing bit drives transmitter level
// - filter bit selects filtered samples
// - Q unstable when Q changed while filtering
// - I unstable when I changed while filtering
`timescale 1ns/100ps
`include "card_detect_cfg.svh"
module card_detect_threshold_regs #(
  parameter bit NEWER_VARIANT = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic measStart,
  input wire logic measSample,
  input wire card_detect_pkg::meas_t iSample,
  input wire card_detect_pkg::meas_t qSample,
  input wire logic measDone,
  output logic cardDetectIrqFlag,
  output logic txFullSwing,
  output logic irq
);
  import card_detect_pkg::*;

  localparam int SAMPLE_CYC = (`SAMPLE_CYCLES < 1) ? 1 : `SAMPLE_CYCLES;
  localparam int CNT_W = $clog2(SAMPLE_CYC + 1);

  // Window counter saturates at the sampling limit, so a front end
  // that never sends its end pulse leaves the block in MEAS_RUN but harmless:
  // later samples are dropped until the next start pulse reopens it.
  // The counter is cleared on every start, so back to back procedures
  // each get the full sampling time.

  reg8_t qLow_r;
  reg8_t qHigh_r;
  reg8_t iLow_r;
  meas_t iRes_r;
  meas_t qRes_r;
  logic suppress_r;
  logic txFull_r;
  logic filterEn_r;
  logic qUnstable_r;
  logic iUnstable_r;
  evt_t evtStat_r;
  evt_t evtMask_r;
  evt_t evtStat_nxt;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic irq_r;
  logic detFlag_r;
  meas_state_t state_r;
  logic [CNT_W-1:0] winCnt_r;
  logic firstSeen_r;
  meas_t iFirst_r;
  meas_t qFirst_r;
  meas_t iFilt_r;
  meas_t qFilt_r;
  meas_t iRaw_r;
  meas_t qRaw_r;
  logic iChg_r;
  logic qChg_r;

  // Bus decode
  // Exactly one wait state: the access cycle sets pready_r, and the
  // transfer commits at the following edge, when pready_r is seen high.
  // Writes and read side effects are qualified by that commit edge only,
  // so a master that stretches the setup phase changes nothing early.
  logic [ADDR_W-3:0] idx;
  logic accessPh;
  logic wrEn;
  logic rdEn;
  logic optHit;
  logic mapped;
  reg8_t rdByte;
  assign idx = paddr[ADDR_W-1:2];
  assign accessPh = psel && penable && !pready_r;
  assign wrEn = psel && penable && pready_r && pwrite && mapped;
  assign rdEn = psel && penable && pready_r && !pwrite && mapped;
  assign optHit = NEWER_VARIANT && (idx == (ADDR_W-2)'(`IDX_OPTIONS));

  // Map and read mux
  // Reserved bits read as zero; an unmapped index answers with an error
  // and zero data, and no register moves.
  // The options index falls through to unmapped on the older variant.
  always_comb begin
    mapped = 1'b1;
    rdByte = `REG8_RESET;
    if (optHit) begin
      rdByte[`TX_FULL_BIT] = txFull_r;
      rdByte[`FILTER_BIT] = filterEn_r;
      rdByte[`Q_UNSTABLE_BIT] = qUnstable_r;
      rdByte[`I_UNSTABLE_BIT] = iUnstable_r;
    end else if (idx == (ADDR_W-2)'(`IDX_Q_LOW)) begin
      rdByte = qLow_r;
    end else if (idx == (ADDR_W-2)'(`IDX_Q_HIGH)) begin
      rdByte = qHigh_r;
    end else if (idx == (ADDR_W-2)'(`IDX_I_LOW)) begin
      rdByte = iLow_r;
    end else if (idx == (ADDR_W-2)'(`IDX_I_RES)) begin
      rdByte[`THR_MSB:`THR_LSB] = iRes_r;
    end else if (idx == (ADDR_W-2)'(`IDX_Q_RES)) begin
      rdByte[`SUPPRESS_BIT] = suppress_r;
      rdByte[`THR_MSB:`THR_LSB] = qRes_r;
    end else if (idx == (ADDR_W-2)'(`IDX_IRQ_STAT)) begin
      rdByte[1:0] = evtStat_r;
    end else if (idx == (ADDR_W-2)'(`IDX_IRQ_MASK)) begin
      rdByte[1:0] = evtMask_r;
    end else begin
      mapped = 1'b0;
    end
  end

  // One wait state, answer registered
  // Read data is zero outside the answer cycle, so a monitor can
  // check it without knowing the direction of the transfer.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= `DATA_RESET;
    end else begin
      pready_r <= accessPh;
      pslverr_r <= accessPh && !mapped;
      if (accessPh && !pwrite) begin
        prdata_r <= {24'h00_0000, rdByte};
      end else begin
        prdata_r <= `DATA_RESET;
      end
    end
  end

  // Threshold registers
  // Upper I threshold bits live in the top pairs of these bytes;
  // a whole byte write updates both fields together, so software
  // must write all three bytes before a new upper I limit is valid.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      qLow_r <= `REG8_RESET;
      qHigh_r <= `REG8_RESET;
      iLow_r <= `REG8_RESET;
    end else if (wrEn) begin
      if (idx == (ADDR_W-2)'(`IDX_Q_LOW)) begin
        qLow_r <= pwdata[7:0];
      end
      if (idx == (ADDR_W-2)'(`IDX_Q_HIGH)) begin
        qHigh_r <= pwdata[7:0];
      end
      if (idx == (ADDR_W-2)'(`IDX_I_LOW)) begin
        iLow_r <= pwdata[7:0];
      end
    end
  end

  // Options; ignored writes on older variant
  // Unstable flags are not written here; they follow the measurement.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txFull_r <= 1'b0;
      filterEn_r <= 1'b0;
    end else if (wrEn && optHit) begin
      txFull_r <= pwdata[`TX_FULL_BIT];
      filterEn_r <= pwdata[`FILTER_BIT];
    end
  end

  // Suppress bit; a new procedure re-arms detection
  // A software write wins over a start pulse in the same cycle,
  // so a suppress set by software is never silently lost.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      suppress_r <= 1'b0;
    end else if (wrEn && idx == (ADDR_W-2)'(`IDX_Q_RES)) begin
      suppress_r <= pwdata[`SUPPRESS_BIT];
    end else if (measStart) begin
      suppress_r <= 1'b0;
    end
  end

  // Measurement window
  // End pulse closes the window at any count; a late end still
  // evaluates whatever samples were taken inside the window.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= MEAS_IDLE;
      winCnt_r <= '0;
    end else if (measStart) begin
      state_r <= MEAS_RUN;
      winCnt_r <= '0;
    end else if (measDone) begin
      state_r <= MEAS_IDLE;
    end else if (state_r == MEAS_RUN && winCnt_r != CNT_W'(SAMPLE_CYC)) begin
      winCnt_r <= winCnt_r + CNT_W'(1);
    end
  end

  // Sample accepted while window open
  logic takeSample;
  assign takeSample = measSample && state_r == MEAS_RUN
                      && winCnt_r != CNT_W'(SAMPLE_CYC);

  // Halves of filtered running mean
  // Carry bit keeps the sum exact before halving, so the mean
  // never wraps for full scale samples.
  logic [6:0] iSum;
  logic [6:0] qSum;
  assign iSum = {1'b0, iFilt_r} + {1'b0, iSample};
  assign qSum = {1'b0, qFilt_r} + {1'b0, qSample};

  // Raw, filtered and change tracking
  // Every later sample is compared with the first of the procedure,
  // so a slow drift counts as a change just like a single jump.
  // Raw values are kept too, so the filter can be toggled between runs.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      firstSeen_r <= 1'b0;
      iFirst_r <= '0;
      qFirst_r <= '0;
      iFilt_r <= '0;
      qFilt_r <= '0;
      iRaw_r <= '0;
      qRaw_r <= '0;
      iChg_r <= 1'b0;
      qChg_r <= 1'b0;
    end else if (measStart) begin
      firstSeen_r <= 1'b0;
      iChg_r <= 1'b0;
      qChg_r <= 1'b0;
    end else if (takeSample) begin
      firstSeen_r <= 1'b1;
      iRaw_r <= iSample;
      qRaw_r <= qSample;
      if (!firstSeen_r) begin
        iFirst_r <= iSample;
        qFirst_r <= qSample;
        iFilt_r <= iSample;
        qFilt_r <= qSample;
      end else begin
        iFilt_r <= iSum[6:1];
        qFilt_r <= qSum[6:1];
        iChg_r <= iChg_r || (iSample != iFirst_r);
        qChg_r <= qChg_r || (qSample != qFirst_r);
      end
    end
  end

  // Decision inputs and compares
  // Q against its lower threshold fires on above, as defined for
  // this block; all four compares are strict, so equal never fires.
  // Suppression gates only the decision, results still update.
  meas_t iVal;
  meas_t qVal;
  meas_t iUpper;
  logic detectHit;
  logic unstableHit;
  assign iVal = filterEn_r ? iFilt_r : iRaw_r;
  assign qVal = filterEn_r ? qFilt_r : qRaw_r;
  assign iUpper = {qLow_r[`IUP_MSB:`IUP_LSB], qHigh_r[`IUP_MSB:`IUP_LSB],
                   iLow_r[`IUP_MSB:`IUP_LSB]};
  assign detectHit = measDone && !suppress_r && (
    (iVal > iUpper) ||
    (qVal > qLow_r[`THR_MSB:`THR_LSB]) ||
    (qVal > qHigh_r[`THR_MSB:`THR_LSB]) ||
    (iVal < iLow_r[`THR_MSB:`THR_LSB]));
  assign unstableHit = measDone && filterEn_r && (iChg_r || qChg_r);

  // Results and unstable flags latched at done
  // Both results move at the same edge, so a read never pairs
  // an I value of one procedure with a Q value of another.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      iRes_r <= '0;
      qRes_r <= '0;
      iUnstable_r <= 1'b0;
      qUnstable_r <= 1'b0;
      detFlag_r <= 1'b0;
    end else begin
      detFlag_r <= detectHit;
      if (measDone) begin
        iRes_r <= iVal;
        qRes_r <= qVal;
        iUnstable_r <= filterEn_r && iChg_r;
        qUnstable_r <= filterEn_r && qChg_r;
      end
    end
  end

  // Sticky events, read clears, set wins
  // An event in the cycle of a clearing read stays visible,
  // but a detection in the preceding wait cycle is cleared unread, so software can miss it.
  always_comb begin
    evtStat_nxt = evtStat_r;
    if (rdEn && idx == (ADDR_W-2)'(`IDX_IRQ_STAT)) begin
      evtStat_nxt = `EVT_RESET;
    end
    if (detectHit) begin
      evtStat_nxt[`EVT_DETECT_BIT] = 1'b1;
    end
    if (unstableHit) begin
      evtStat_nxt[`EVT_UNSTABLE_BIT] = 1'b1;
    end
  end

  // Status, mask and interrupt line
  // Line uses the next status value, so it follows a set or a
  // clear at the same edge as the status bit, with no lag.
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      evtStat_r <= `EVT_RESET;
      evtMask_r <= `EVT_RESET;
      irq_r <= 1'b0;
    end else begin
      evtStat_r <= evtStat_nxt;
      if (wrEn && idx == (ADDR_W-2)'(`IDX_IRQ_MASK)) begin
        evtMask_r <= pwdata[1:0];
      end
      irq_r <= |(evtStat_nxt & evtMask_r);
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign cardDetectIrqFlag = detFlag_r;
  assign txFullSwing = txFull_r;
  assign irq = irq_r;
endmodule

// [bench/card_detect_threshold_regs_properties.sv]
// Checker of APB timing, refusals and detect pulses.
// Bound to card_detect_threshold_regs, sees its ports only.
`timescale 1ns/100ps
module card_detect_threshold_regs_properties #(
  parameter bit NEWER_VARIANT = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic measStart,
  input wire logic measSample,
  input wire card_detect_pkg::meas_t iSample,
  input wire card_detect_pkg::meas_t qSample,
  input wire logic measDone,
  input wire logic cardDetectIrqFlag,
  input wire logic txFullSwing,
  input wire logic irq
);
  import card_detect_pkg::*;
  logic [9:0] idx;
  logic xfer;
  logic mapped;
  // Decode of the transfer that completes
  assign idx = 10'(paddr >> 2);
  assign xfer = psel && penable && pready;
  assign mapped = (idx >= 10'h03f && idx <= 10'h043) || idx == 10'h050 || idx == 10'h051 ||
    (NEWER_VARIANT && idx == 10'h03a);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  AST_WAIT_ONE: assert property ($rose(psel && penable) |=> pready)
    else $error("answer not after one wait");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (xfer && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped place not refused");
  AST_OK_MAPPED: assert property (xfer && mapped |-> !pslverr)
    else $error("mapped place refused");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data outside answer");
  AST_FLAG_CAUSE: assert property (cardDetectIrqFlag |-> $past(measDone))
    else $error("detect pulse without end");
  AST_SWING_WRITE: assert property (xfer && pwrite && idx == 10'h03a && NEWER_VARIANT |->
    ##2 txFullSwing == $past(pwdata[3], 2)) else $error("swing not from write");
  AST_SWING_HOLD: assert property ($changed(txFullSwing) |-> $past(xfer) || $past(xfer, 2))
    else $error("swing moved alone");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(xfer) || $past(xfer, 2))
    else $error("irq fell without access");
endmodule

bind card_detect_threshold_regs card_detect_threshold_regs_properties #(.NEWER_VARIANT(NEWER_VARIANT),
  .ADDR_W(ADDR_W)) card_detect_threshold_regs_properties_inst (.clk_sys(clk_sys), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .measStart(measStart), .measSample(measSample),
  .iSample(iSample), .qSample(qSample), .measDone(measDone), .cardDetectIrqFlag(cardDetectIrqFlag),
  .txFullSwing(txFullSwing), .irq(irq));

// [bench/front_end_model.sv]
// Model of the measurement front end: start, samples, end.
// Assumes the caller runs on clk_sys; outputs move after edges.
`timescale 1ns/100ps
module front_end_model (
  input wire logic clk_sys,
  output logic measStart,
  output logic measSample,
  output card_detect_pkg::meas_t iSample,
  output card_detect_pkg::meas_t qSample,
  output logic measDone
);
  import card_detect_pkg::*;
  // Quiet lines at time zero
  initial begin
    measStart = 1'b0;
    measSample = 1'b0;
    measDone = 1'b0;
    iSample = 6'h2a;
    qSample = 6'h15;
  end
  // Opens a detection procedure
  task automatic open_meas();
    @(posedge clk_sys);
    measStart <= 1'b1;
    @(posedge clk_sys);
    measStart <= 1'b0;
  endtask
  // Two samples then the end pulse; data inverted once unused
  task automatic close_meas(input meas_t i0, q0, i1, q1);
    @(posedge clk_sys);
    measSample <= 1'b1;
    iSample <= i0;
    qSample <= q0;
    @(posedge clk_sys);
    iSample <= i1;
    qSample <= q1;
    @(posedge clk_sys);
    measSample <= 1'b0;
    measDone <= 1'b1;
    iSample <= ~i1;
    qSample <= ~q1;
    @(posedge clk_sys);
    measDone <= 1'b0;
  endtask
endmodule

// [bench/card_detect_threshold_regs_test.sv]
// Self-checking bench of the card presence detect registers.
// Drives APB itself; the front end model makes measurements.
`timescale 1ns/100ps
module card_detect_threshold_regs_test;
  import card_detect_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, measStart, measSample, measDone, cardDetectIrqFlag, txFullSwing, irq;
  meas_t iSample, qSample;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  // Options, thresholds, results, status, mask
  logic [11:0] adr [8] = '{12'h0e8, 12'h0fc, 12'h100, 12'h104, 12'h108, 12'h10c, 12'h140, 12'h144};
  // Q low, Q high, I low bytes, then I, Q, detect
  logic [47:0] tbl [8] = '{48'hbf7fc5_270a00, 48'hbf7fc5_280a01, 48'hbf7fc5_053f00, 48'hbf7fc5_040a01,
    48'h947fc5_0a1400, 48'h947fc5_0a1501, 48'hbf5ec5_0a1f01, 48'hbf5ec5_0a1e00};

  card_detect_threshold_regs card_detect_threshold_regs_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .measStart(measStart), .measSample(measSample),
    .iSample(iSample), .qSample(qSample), .measDone(measDone), .cardDetectIrqFlag(cardDetectIrqFlag),
    .txFullSwing(txFullSwing), .irq(irq));
  front_end_model front_end_model_inst (.clk_sys(clk_sys), .measStart(measStart),
    .measSample(measSample), .iSample(iSample), .qSample(qSample), .measDone(measDone));

  // Clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task conclude();
    if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One APB transfer; holds until pready is seen at an edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(nm, rd, exp);
  endtask

  task automatic meas(input meas_t i0, q0, i1, q1);
    front_end_model_inst.open_meas();
    front_end_model_inst.close_meas(i0, q0, i1, q1);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    check("outs", 32'({cardDetectIrqFlag, txFullSwing, irq}), 32'h0);
    rst_b <= 1'b1;
    foreach (adr[k]) rchk("reset", adr[k], 32'h0);
    foreach (tbl[k]) begin
      apb(12'h0fc, 1'b1, 32'(tbl[k][47:40]));
      apb(12'h100, 1'b1, 32'(tbl[k][39:32]));
      apb(12'h104, 1'b1, 32'(tbl[k][31:24]));
      rchk("qLow", 12'h0fc, 32'(tbl[k][47:40]));
      meas(tbl[k][21:16], tbl[k][13:8], tbl[k][21:16], tbl[k][13:8]);
      #1 check("flag", cardDetectIrqFlag, 32'(tbl[k][0]));
      check("irqMasked", irq, 32'h0);
      rchk("iRes", 12'h108, 32'(tbl[k][21:16]));
      rchk("qRes", 12'h10c, 32'(tbl[k][13:8]));
      rchk("status", 12'h140, 32'(tbl[k][0]));
    end
    apb(12'h108, 1'b1, 32'hff);
    rchk("iResRo", 12'h108, 32'h0a);
    rchk("gap", 12'h0ec, 32'h0);
    check("gapErr", err, 32'h1);
    // Interrupt raised when unmasked, cleared by status read
    apb(12'h144, 1'b1, 32'h1);
    meas(6'h28, 6'h0a, 6'h28, 6'h0a);
    #1 check("irqOn", irq, 32'h1);
    rchk("status1", 12'h140, 32'h1);
    @(posedge clk_sys);
    #1 check("irqOff", irq, 32'h0);
    // Suppression holds until the next procedure
    front_end_model_inst.open_meas();
    apb(12'h10c, 1'b1, 32'h40);
    rchk("suppress", 12'h10c, 32'h4a);
    front_end_model_inst.close_meas(6'h28, 6'h0a, 6'h28, 6'h0a);
    #1 check("flagSup", cardDetectIrqFlag, 32'h0);
    meas(6'h28, 6'h0a, 6'h28, 6'h0a);
    #1 check("flagBack", cardDetectIrqFlag, 32'h1);
    rchk("supClr", 12'h10c, 32'h0a);
    // Options: swing, filtered decision, unstable flags
    apb(12'h0e8, 1'b1, 32'hff);
    rchk("opt", 12'h0e8, 32'h0c);
    check("swingOn", txFullSwing, 32'h1);
    apb(12'h0e8, 1'b1, 32'h04);
    meas(6'h00, 6'h0a, 6'h08, 6'h0a);
    #1 check("flagFilt", cardDetectIrqFlag, 32'h1);
    rchk("iUnstable", 12'h0e8, 32'h05);
    meas(6'h0a, 6'h0a, 6'h0a, 6'h14);
    #1 check("flagQ", cardDetectIrqFlag, 32'h0);
    rchk("qUnstable", 12'h0e8, 32'h06);
    rchk("statUnst", 12'h140, 32'h3);
    check("swingOff", txFullSwing, 32'h0);
    conclude();
  end
endmodule
